//--- bench/ass_field_model.sv
`timescale 1ns/10ps
// Field side: detectors, abort switch and manual station. Each contact is
// registered so it changes only at a clock edge, like a debounced input.
module ass_field_model (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic want_a,
  input  wire logic want_b,
  input  wire logic want_c1,
  input  wire logic want_c2,
  input  wire logic want_man,
  input  wire logic want_abort,
  output logic      zone_a_alarm,
  output logic      zone_b_alarm,
  output logic      count_alarm_1,
  output logic      count_alarm_2,
  output logic      manual_release,
  output logic      abort_switch
);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {zone_a_alarm, zone_b_alarm, count_alarm_1} <= 3'h0;
      {count_alarm_2, manual_release, abort_switch} <= 3'h0;
    end else begin
      {zone_a_alarm, zone_b_alarm, count_alarm_1} <= {want_a, want_b, want_c1};
      {count_alarm_2, manual_release, abort_switch} <=
        {want_c2, want_man, want_abort};
    end
  end
endmodule

//--- bench/ass_seq_tb_top.sv
`timescale 1ns/10ps
module ass_seq_tb_top;
  import ass_pkg::*;
  logic clk_sys, nrst, w_a, w_b, w_c1, w_c2, w_man, w_abort;
  logic za, zb, c1, c2, man, abt, ev_det, ev_sta, ev_wf, dly_en, ver_en;
  logic ack, pre_low, smoke_hi, sup, trb, dis, spr, abt_act, horn, strobe;
  logic [1:0] pat;
  logic [7:0] rel_dly;
  logic [7:0] tleft;
  logic [2:0] lvl;
  int bad_count = 0;
  int num_checks = 0;

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  ass_field_model ass_field_model_i (.clk_sys(clk_sys), .nrst(nrst),
    .want_a(w_a), .want_b(w_b), .want_c1(w_c1), .want_c2(w_c2),
    .want_man(w_man), .want_abort(w_abort), .zone_a_alarm(za),
    .zone_b_alarm(zb), .count_alarm_1(c1), .count_alarm_2(c2),
    .manual_release(man), .abort_switch(abt));

  ass_seq #(.TICK_CYC(10)) ass_seq_i (.clk_sys(clk_sys), .nrst(nrst),
    .zone_a_alarm(za), .zone_b_alarm(zb), .count_alarm_1(c1),
    .count_alarm_2(c2), .manual_release(man), .abort_switch(abt),
    .release_delay(rel_dly), .evac_detector(ev_det), .evac_station(ev_sta),
    .evac_waterflow(ev_wf), .delayed_evac_enable(dly_en),
    .verify_enable(ver_en), .evac_delay(8'h04), .evac_ack(ack),
    .prealarm_low(pre_low), .high_sensitivity_smoke_detector(smoke_hi),
    .supervisory(sup), .trouble(trb), .discharge(dis),
    .sprinkler_valve(spr), .notify_pattern(pat), .abort_active(abt_act),
    .temporal_horn(horn), .temporal_strobe(strobe), .time_left(tleft),
    .display_level(lvl));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic do_reset(input int n);
    nrst = 1'b0;
    {w_a, w_b, w_c1, w_c2, w_man, w_abort} = 6'h00;
    {ev_det, ev_sta, ev_wf, dly_en, ver_en, ack} = 6'h00;
    {pre_low, smoke_hi, sup, trb} = 4'h0;
    rel_dly = 8'h05;
    cyc(n);
    nrst = 1'b1;
    cyc(1);
    chk({dis, spr, pat, horn, strobe, abt_act}, 8'h00, "outputs after reset");
    chk(tleft, 8'h00, "timer after reset");
    chk(lvl, LVL_NONE, "level after reset");
  endtask

  task automatic t_cross;
    int i;
    w_a = 1'b1;
    cyc(4);
    chk(pat, PAT_PREALM, "prealarm pattern");
    chk(lvl, LVL_3, "prealarm level");
    w_b = 1'b1;
    for (i = 0; i < 10 && pat !== PAT_COUNT; i++) cyc(1);
    chk(pat, PAT_COUNT, "countdown pattern");
    chk(tleft, 8'h05, "delay loaded");
    cyc(2);
    chk(lvl, LVL_1, "countdown level");
    for (i = 0; i < 30 && tleft === 8'h05; i++) cyc(1);
    chk(tleft, 8'h04, "one step per second");
    chk(dis, 1'b0, "no early discharge");
    for (i = 0; i < 80 && dis !== 1'b1; i++) cyc(1);
    chk(dis, 1'b1, "discharge at expiry");
    chk(spr, 1'b1, "valve with discharge");
    chk(pat, PAT_RELEASE, "release pattern");
    cyc(2);
    chk(lvl, LVL_2, "release level");
    $display("cross zone test done");
  endtask

  task automatic t_abort;
    w_abort = 1'b1;
    w_c1 = 1'b1;
    w_c2 = 1'b1;
    cyc(5);
    chk(abt_act, 1'b1, "abort active");
    chk(lvl, LVL_2, "abort level");
    cyc(80);
    chk(dis, 1'b0, "abort blocks discharge");
    rel_dly = 8'h03;
    w_abort = 1'b0;
    cyc(2);
    chk(pat, PAT_COUNT, "countdown after abort drop");
    chk(abt_act, 1'b0, "abort cleared");
    chk(tleft, 8'h03, "new delay loaded");
    w_abort = 1'b1;
    cyc(4);
    chk(abt_act, 1'b1, "abort halts countdown");
    cyc(80);
    chk(dis, 1'b0, "halted countdown never releases");
    $display("abort test done");
  endtask

  task automatic t_manual;
    w_man = 1'b1;
    cyc(2);
    chk({dis, spr}, 8'h03, "manual release at once");
    chk(pat, PAT_RELEASE, "manual release pattern");
    $display("manual test done");
  endtask

  task automatic t_evac;
    ev_wf = 1'b1;
    cyc(4);
    chk({horn, strobe}, 8'h03, "temporal outputs");
    chk(lvl, LVL_2, "evac alarm level");
    $display("evacuation test done");
  endtask

  task automatic t_subalarm;
    int i;
    ver_en = 1'b1;
    ev_det = 1'b1;
    cyc(3);
    chk(lvl, LVL_4, "verification level");
    chk({horn, strobe}, 8'h00, "verification holds horn");
    ev_det = 1'b0;
    cyc(3);
    chk(lvl, LVL_NONE, "verification cleared");
    ver_en = 1'b0;
    dly_en = 1'b1;
    ev_det = 1'b1;
    cyc(3);
    chk(lvl, LVL_2, "delayed evacuation level");
    chk({horn, strobe}, 8'h00, "delayed evacuation holds horn");
    ev_det = 1'b0;
    ack = 1'b1;
    cyc(3);
    chk(lvl, LVL_NONE, "acknowledged and cleared");
    ack = 1'b0;
    ev_det = 1'b1;
    cyc(20);
    chk(horn, 1'b0, "horn waits for delay");
    for (i = 0; i < 80 && horn !== 1'b1; i++) cyc(1);
    chk({horn, strobe}, 8'h03, "horn after delay");
    $display("sub-alarm test done");
  endtask

  task automatic t_levels;
    sup = 1'b1;
    smoke_hi = 1'b1;
    cyc(4);
    chk(lvl, LVL_5, "lowest level");
    pre_low = 1'b1;
    cyc(4);
    chk(lvl, LVL_3, "higher level hides lower");
    $display("level test done");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #2000000;
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    do_reset(16);
    t_cross();
    do_reset(4);
    t_abort();
    do_reset(4);
    t_manual();
    do_reset(4);
    t_evac();
    do_reset(4);
    t_subalarm();
    do_reset(4);
    t_levels();
    do_reset(4);
    conclude();
  end
endmodule

//--- inc/ass_pkg.sv
package ass_pkg;
  localparam int CLK_HZ          = 10000000;
  localparam int TICK_PERIOD_S   = 1;
  localparam int TICK_CYCLES     = CLK_HZ * TICK_PERIOD_S;
  localparam int DELAY_W         = 8;
  localparam logic [7:0] DELAY_RST = 8'h1E;
  localparam int VERIFY_W        = 8;
  localparam logic [7:0] VERIFY_RST = 8'h3C;
  localparam int LEVEL_W         = 3;
  localparam logic [2:0] LVL_NONE = 3'h0;
  localparam logic [2:0] LVL_1    = 3'h1;
  localparam logic [2:0] LVL_2    = 3'h2;
  localparam logic [2:0] LVL_3    = 3'h3;
  localparam logic [2:0] LVL_4    = 3'h4;
  localparam logic [2:0] LVL_5    = 3'h5;
  localparam int PAT_W           = 2;
  localparam logic [1:0] PAT_OFF     = 2'h0;
  localparam logic [1:0] PAT_PREALM  = 2'h1;
  localparam logic [1:0] PAT_COUNT   = 2'h2;
  localparam logic [1:0] PAT_RELEASE = 2'h3;

  typedef enum {
    ASS_IDLE, ASS_PREALM, ASS_COUNT, ASS_RELEASE, ASS_ABORT
  } ass_supp_t;

  typedef enum {
    ASS_EV_IDLE, ASS_EV_VERIFY, ASS_EV_DELAYED, ASS_EV_ALARM
  } ass_evac_t;
endpackage

//--- inc/ass_tick_if.sv
`timescale 1ns/10ps
interface ass_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

//--- rtl/ass_seq.sv
// Functional notes
// - One zone detector alarm enters pre-alarm.
// - Two alarms of one pair (zone A and B, or count 1 and 2) enter countdown state.
// - Countdown entry loads the configurable delay.
// - Delay expiry enters release, asserts discharge.
// - Manual release forces release with no delay.
// - Sprinkler valve released together with discharge.
// - Pre-alarm and countdown patterns differ.
// - Release pattern differs from both others.
// - Abort halts or blocks the countdown.
// - Evacuation alarm from detector, station, waterflow.
// - Evacuation alarm drives temporal horn, strobe.
// - Delayed evacuation and verification delay alarm.
// - Events ranked into five priority levels.
// - Sensitive smoke warnings ranked lowest level.
// - Display shows only the highest active level.
// - Remaining time decrements once per second.
`timescale 1ns/10ps
module ass_seq #(
  parameter int TICK_CYC = ass_pkg::TICK_CYCLES
) (
  input  wire logic                        clk_sys,
  input  wire logic                        nrst,
  input  wire logic                        zone_a_alarm,
  input  wire logic                        zone_b_alarm,
  input  wire logic                        count_alarm_1,
  input  wire logic                        count_alarm_2,
  input  wire logic                        manual_release,
  input  wire logic                        abort_switch,
  input  wire logic [ass_pkg::DELAY_W-1:0] release_delay,
  input  wire logic                        evac_detector,
  input  wire logic                        evac_station,
  input  wire logic                        evac_waterflow,
  input  wire logic                        delayed_evac_enable,
  input  wire logic                        verify_enable,
  input  wire logic [ass_pkg::DELAY_W-1:0] evac_delay,
  input  wire logic                        evac_ack,
  input  wire logic                        prealarm_low,
  input  wire logic                        high_sensitivity_smoke_detector,
  input  wire logic                        supervisory,
  input  wire logic                        trouble,
  output logic                             discharge,
  output logic                             sprinkler_valve,
  output logic [ass_pkg::PAT_W-1:0]        notify_pattern,
  output logic                             abort_active,
  output logic                             temporal_horn,
  output logic                             temporal_strobe,
  output logic [ass_pkg::DELAY_W-1:0]      time_left,
  output logic [ass_pkg::LEVEL_W-1:0]      display_level
);
  import ass_pkg::*;

  if (TICK_CYC < 2) begin : g_bad_tick
    $error("ass_seq: TICK_CYC too small");
  end

  ass_tick_if tk ();

  ass_tick #(.CYCLES(TICK_CYC)) u_tick (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .tk      (tk)
  );

  ass_supp_t             st;
  ass_supp_t             next_st;
  logic [DELAY_W-1:0]    cnt;
  logic [DELAY_W-1:0]    next_cnt;
  logic                  one_alarm;
  logic                  two_alarm;
  logic                  next_discharge;
  logic [PAT_W-1:0]      next_pattern;

  assign one_alarm = zone_a_alarm | zone_b_alarm | count_alarm_1
                   | count_alarm_2;
  assign two_alarm = (zone_a_alarm & zone_b_alarm)
                   | (count_alarm_1 & count_alarm_2);

  // Release latches until reset; an abort cannot recall discharged agent.
  always_comb begin
    next_st  = st;
    next_cnt = cnt;
    unique case (st)
      ASS_IDLE, ASS_PREALM: begin
        if (one_alarm) begin
          next_st = ASS_PREALM;
        end
        if (two_alarm) begin
          if (abort_switch) begin
            next_st = ASS_ABORT;
          end else begin
            next_st  = ASS_COUNT;
            next_cnt = release_delay;
          end
        end
      end
      ASS_COUNT: begin
        if (abort_switch) begin
          next_st = ASS_ABORT;
        end else if (cnt == '0) begin
          next_st = ASS_RELEASE;
        end else if (tk.tick) begin
          next_cnt = cnt - DELAY_W'(1);
        end
      end
      ASS_ABORT: begin
        if (!abort_switch && two_alarm) begin
          next_st  = ASS_COUNT;
          next_cnt = release_delay;
        end
      end
      ASS_RELEASE: begin
        next_st = ASS_RELEASE;
      end
    endcase
    if (manual_release) begin
      next_st = ASS_RELEASE;
    end
  end

  always_comb begin
    next_discharge = (next_st == ASS_RELEASE);
    unique case (next_st)
      ASS_PREALM:  next_pattern = PAT_PREALM;
      ASS_COUNT:   next_pattern = PAT_COUNT;
      ASS_RELEASE: next_pattern = PAT_RELEASE;
      ASS_ABORT:   next_pattern = PAT_COUNT;
      ASS_IDLE:    next_pattern = PAT_OFF;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st              <= ASS_IDLE;
      cnt             <= '0;
      discharge       <= 1'b0;
      sprinkler_valve <= 1'b0;
      notify_pattern  <= PAT_OFF;
      abort_active    <= 1'b0;
      time_left       <= '0;
    end else begin
      st              <= next_st;
      cnt             <= next_cnt;
      discharge       <= next_discharge;
      sprinkler_valve <= next_discharge;
      notify_pattern  <= next_pattern;
      abort_active    <= (next_st == ASS_ABORT);
      time_left       <= next_cnt;
    end
  end

  // Evacuation path.
  ass_evac_t             ev;
  ass_evac_t             next_ev;
  logic [DELAY_W-1:0]    ecnt;
  logic [DELAY_W-1:0]    next_ecnt;
  logic                  evac_in;
  logic                  next_horn;

  assign evac_in = evac_detector | evac_station | evac_waterflow;

  // A manual station or waterflow is never delayed; only detectors are.
  always_comb begin
    next_ev   = ev;
    next_ecnt = ecnt;
    unique case (ev)
      ASS_EV_IDLE: begin
        if (evac_station || evac_waterflow) begin
          next_ev = ASS_EV_ALARM;
        end else if (evac_detector) begin
          if (delayed_evac_enable) begin
            next_ev   = ASS_EV_DELAYED;
            next_ecnt = evac_delay;
          end else if (verify_enable) begin
            next_ev   = ASS_EV_VERIFY;
            next_ecnt = evac_delay;
          end else begin
            next_ev = ASS_EV_ALARM;
          end
        end
      end
      ASS_EV_DELAYED, ASS_EV_VERIFY: begin
        if (evac_station || evac_waterflow) begin
          next_ev = ASS_EV_ALARM;
        end else if (ev == ASS_EV_VERIFY && !evac_detector) begin
          next_ev = ASS_EV_IDLE;
        end else if (ev == ASS_EV_DELAYED && evac_ack && !evac_detector) begin
          next_ev = ASS_EV_IDLE;
        end else if (ecnt == '0) begin
          next_ev = ASS_EV_ALARM;
        end else if (tk.tick) begin
          next_ecnt = ecnt - DELAY_W'(1);
        end
      end
      ASS_EV_ALARM: begin
        next_ev = ASS_EV_ALARM;
      end
    endcase
    next_horn = (next_ev == ASS_EV_ALARM);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ev              <= ASS_EV_IDLE;
      ecnt            <= '0;
      temporal_horn   <= 1'b0;
      temporal_strobe <= 1'b0;
    end else begin
      ev              <= next_ev;
      ecnt            <= next_ecnt;
      temporal_horn   <= next_horn;
      temporal_strobe <= next_horn;
    end
  end

  // Priority ranking; the display shows only the top level present.
  logic [LEVEL_W-1:0] next_level;

  always_comb begin
    next_level = LVL_NONE;
    if (supervisory || trouble || high_sensitivity_smoke_detector) begin
      next_level = LVL_5;
    end
    if (ev == ASS_EV_VERIFY) begin
      next_level = LVL_4;
    end
    if (prealarm_low || st == ASS_PREALM) begin
      next_level = LVL_3;
    end
    if (st == ASS_RELEASE || st == ASS_ABORT || ev == ASS_EV_ALARM
        || ev == ASS_EV_DELAYED) begin
      next_level = LVL_2;
    end
    if (st == ASS_COUNT) begin
      next_level = LVL_1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      display_level <= LVL_NONE;
    end else begin
      display_level <= next_level;
    end
  end

  chk_release_outputs: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    discharge |-> sprinkler_valve && notify_pattern == PAT_RELEASE)
    else $error("release outputs not together");

  chk_manual_release: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    manual_release |=> discharge)
    else $error("manual release not immediate");

  chk_abort_blocks: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (st == ASS_COUNT && abort_switch && !manual_release) |=> !discharge)
    else $error("abort did not block discharge");

  chk_count_pattern: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (st == ASS_COUNT) |-> notify_pattern == PAT_COUNT)
    else $error("countdown pattern wrong");

  chk_one_alarm: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (st == ASS_IDLE && one_alarm && !two_alarm && !manual_release)
      |=> notify_pattern == PAT_PREALM)
    else $error("pre-alarm not entered");

  chk_two_alarm: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (st == ASS_PREALM && two_alarm && !abort_switch && !manual_release)
      |=> st == ASS_COUNT && time_left == $past(release_delay))
    else $error("countdown not entered");

  chk_expiry: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (st == ASS_COUNT && cnt == '0 && !abort_switch) |=> discharge)
    else $error("no release at expiry");

  chk_tick_dec: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (st == ASS_COUNT && cnt != '0 && !abort_switch && !manual_release)
      |=> cnt == $past(cnt) - DELAY_W'($past(tk.tick)))
    else $error("countdown step wrong");

  chk_top_level: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (st == ASS_COUNT) |=> display_level == LVL_1)
    else $error("level 1 not shown");

  chk_evac_horn: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ev == ASS_EV_ALARM) |-> temporal_horn && temporal_strobe)
    else $error("evacuation outputs missing");
endmodule

//--- rtl/ass_tick.sv
`timescale 1ns/10ps
module ass_tick #(
  parameter int CYCLES = ass_pkg::TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  ass_tick_if.src  tk
);
  import ass_pkg::*;

  logic [23:0] cnt;
  logic [23:0] next_cnt;
  logic        next_tick;

  // The divider is 24 bits wide, so larger periods cannot be counted.
  if (CYCLES < 2 || CYCLES > 16777215) begin : g_bad_cycles
    $error("ass_tick: CYCLES out of range");
  end

  // One pulse per second paces the countdown.
  always_comb begin
    next_tick = 1'b0;
    next_cnt  = cnt + 24'h000001;
    if (cnt == 24'(CYCLES - 1)) begin
      next_cnt  = 24'h000000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt     <= 24'h000000;
      tk.tick <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      tk.tick <= next_tick;
    end
  end
endmodule
